/* File: hdl/tbw_pkg.sv */
package tbw_pkg;
   localparam logic [7:0] PTR_ADDR = 8'hfd;
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic [3:0] BANK_NORMAL = 4'h0;
   localparam logic [3:0] BANK_TIMER = 4'hd;
   localparam logic [3:0] BANK_SPARE = 4'hf;
   localparam logic [3:0] OFS_CTRL0 = 4'h0;
   localparam logic [3:0] OFS_CTRL1 = 4'h1;
   localparam logic [3:0] OFS_CTRL2 = 4'h2;
   localparam logic [3:0] OFS_BYTE_LOW_HOLD = 4'h4;
   localparam logic [3:0] OFS_BYTE_HIGH_HOLD = 4'h5;
   localparam logic [3:0] OFS_WORD_HOLD_LOW = 4'h6;
   localparam logic [3:0] OFS_WORD_HOLD_HIGH = 4'h7;
   localparam logic [3:0] OFS_WORD_CAP_LOW = 4'h8;
   localparam logic [3:0] OFS_WORD_CAP_HIGH = 4'h9;
   localparam logic [3:0] OFS_BYTE_CAP_LOW = 4'ha;
   localparam logic [3:0] OFS_BYTE_CAP_HIGH = 4'hb;
   localparam int RUN_BIT = 7;
   localparam logic [7:0] REG_RESET = 8'h00;
   typedef enum logic [1:0] {
      TBW_SRC_FILE = 2'b00,
      TBW_SRC_BANK = 2'b01,
      TBW_SRC_PORT = 2'b11
   } tbw_src_t;
endpackage

/* File: hdl/tbw_window.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Pointer upper nibble selects 16-byte working group.
// - Pointer lower nibble selects bank; 0,F,D exist.
// - Bank zero maps to ordinary register file.
// - Nonzero bank replaces lowest sixteen registers.
// - Pointer at 253; D maps controls, 0 ports.
// - High capture loads byte count while high.
// - Low capture loads byte count while low.
// - Word capture high byte at D 09.
// - Word capture low byte at D 08.
// - Word hold high 07, low 06, RW.
// - Byte hold high 05, low 04, RW.
// - Run bit starts, stops, reads timer state.
module tbw_window (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic acc_en,
   input wire logic acc_wr,
   input wire logic acc_short,
   input wire logic [7:0] acc_addr,
   input wire logic [7:0] acc_wdata,
   output logic [7:0] acc_rdata,
   output logic [7:0] file_addr,
   output logic file_sel,
   output logic [1:0] port_sel,
   output logic port_hit,
   input wire logic [7:0] file_rdata,
   input wire logic [7:0] port_rdata,
   input wire logic byte_cap_high_stb,
   input wire logic byte_cap_low_stb,
   input wire logic [7:0] byte_count,
   input wire logic word_cap_stb,
   input wire logic [15:0] word_count,
   input wire logic [7:0] ctrl1_rdata,
   input wire logic [7:0] ctrl2_rdata,
   output logic [7:0] work_group_pointer,
   output logic [7:0] timer_control_zero,
   output logic byte_timer_run_bit,
   output logic [15:0] word_hold,
   output logic [7:0] byte_hold_high_field,
   output logic [7:0] byte_hold_low_field,
   output logic ctrl1_wr,
   output logic ctrl2_wr
);
   logic [7:0] ptr_q;
   logic [7:0] ctrl0_q;
   logic [7:0] bcap_hi_q, bcap_lo_q, wcap_hi_q, wcap_lo_q;
   logic [7:0] whold_hi_q, whold_lo_q, bhold_hi_q, bhold_lo_q;
   logic [7:0] eff_addr;
   logic [3:0] bank;
   logic bank_hit;
   logic wr_en;

   always_comb begin
      if (acc_short) begin
         eff_addr = {ptr_q[7:4], acc_addr[3:0]};
      end else begin
         eff_addr = acc_addr;
      end
   end

   assign bank = ptr_q[3:0];
   // Low sixteen registers swapped out for a nonzero bank.
   assign bank_hit = (bank != tbw_pkg::BANK_NORMAL) && (eff_addr[7:4] == 4'h0);
   assign wr_en = acc_en && acc_wr;

   // Bank zero passes through; low four registers are the ports.
   assign port_hit = acc_en && !bank_hit && (eff_addr[7:2] == 6'h00);
   assign port_sel = eff_addr[1:0];
   assign file_sel = acc_en && !bank_hit && !port_hit && (eff_addr != tbw_pkg::PTR_ADDR);
   assign file_addr = eff_addr;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ptr_q <= tbw_pkg::PTR_RESET;
      end else if (wr_en && eff_addr == tbw_pkg::PTR_ADDR) begin
         ptr_q <= acc_wdata;
      end
   end

   function automatic logic bwr(input logic [3:0] ofs);
      bwr = wr_en && bank_hit && bank == tbw_pkg::BANK_TIMER && eff_addr[3:0] == ofs;
   endfunction

   // Run bit written directly by software.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl0_q <= tbw_pkg::REG_RESET;
      end else if (bwr(tbw_pkg::OFS_CTRL0)) begin
         ctrl0_q <= acc_wdata;
      end
   end
   assign ctrl1_wr = bwr(tbw_pkg::OFS_CTRL1);
   assign ctrl2_wr = bwr(tbw_pkg::OFS_CTRL2);

   // Hardware capture outranks a software write in the same cycle so no measurement is lost.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bcap_hi_q <= tbw_pkg::REG_RESET;
         bcap_lo_q <= tbw_pkg::REG_RESET;
      end else begin
         if (byte_cap_high_stb) begin
            bcap_hi_q <= byte_count;
         end else if (bwr(tbw_pkg::OFS_BYTE_CAP_HIGH)) begin
            bcap_hi_q <= acc_wdata;
         end
         if (byte_cap_low_stb) begin
            bcap_lo_q <= byte_count;
         end else if (bwr(tbw_pkg::OFS_BYTE_CAP_LOW)) begin
            bcap_lo_q <= acc_wdata;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wcap_hi_q <= tbw_pkg::REG_RESET;
         wcap_lo_q <= tbw_pkg::REG_RESET;
      end else begin
         if (word_cap_stb) begin
            wcap_hi_q <= word_count[15:8];
         end else if (bwr(tbw_pkg::OFS_WORD_CAP_HIGH)) begin
            wcap_hi_q <= acc_wdata;
         end
         if (word_cap_stb) begin
            wcap_lo_q <= word_count[7:0];
         end else if (bwr(tbw_pkg::OFS_WORD_CAP_LOW)) begin
            wcap_lo_q <= acc_wdata;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         whold_hi_q <= tbw_pkg::REG_RESET;
         whold_lo_q <= tbw_pkg::REG_RESET;
         bhold_hi_q <= tbw_pkg::REG_RESET;
         bhold_lo_q <= tbw_pkg::REG_RESET;
      end else begin
         if (bwr(tbw_pkg::OFS_WORD_HOLD_HIGH)) begin
            whold_hi_q <= acc_wdata;
         end
         if (bwr(tbw_pkg::OFS_WORD_HOLD_LOW)) begin
            whold_lo_q <= acc_wdata;
         end
         if (bwr(tbw_pkg::OFS_BYTE_HIGH_HOLD)) begin
            bhold_hi_q <= acc_wdata;
         end
         if (bwr(tbw_pkg::OFS_BYTE_LOW_HOLD)) begin
            bhold_lo_q <= acc_wdata;
         end
      end
   end

   // Read mux is combinational, answer in the access cycle.
   always_comb begin
      acc_rdata = 8'h00;
      if (!acc_en) begin
         acc_rdata = 8'h00;
      end else if (eff_addr == tbw_pkg::PTR_ADDR) begin
         acc_rdata = ptr_q;
      end else if (bank_hit) begin
         // Unimplemented banks, F included, read as zero in their low window.
         if (bank == tbw_pkg::BANK_TIMER) begin
            case (eff_addr[3:0])
               tbw_pkg::OFS_CTRL0: acc_rdata = ctrl0_q;
               tbw_pkg::OFS_CTRL1: acc_rdata = ctrl1_rdata;
               tbw_pkg::OFS_CTRL2: acc_rdata = ctrl2_rdata;
               tbw_pkg::OFS_BYTE_LOW_HOLD: acc_rdata = bhold_lo_q;
               tbw_pkg::OFS_BYTE_HIGH_HOLD: acc_rdata = bhold_hi_q;
               tbw_pkg::OFS_WORD_HOLD_LOW: acc_rdata = whold_lo_q;
               tbw_pkg::OFS_WORD_HOLD_HIGH: acc_rdata = whold_hi_q;
               tbw_pkg::OFS_WORD_CAP_LOW: acc_rdata = wcap_lo_q;
               tbw_pkg::OFS_WORD_CAP_HIGH: acc_rdata = wcap_hi_q;
               tbw_pkg::OFS_BYTE_CAP_LOW: acc_rdata = bcap_lo_q;
               tbw_pkg::OFS_BYTE_CAP_HIGH: acc_rdata = bcap_hi_q;
               default: acc_rdata = 8'h00;
            endcase
         end
      end else if (port_hit) begin
         acc_rdata = port_rdata;
      end else begin
         acc_rdata = file_rdata;
      end
   end

   assign work_group_pointer = ptr_q;
   assign timer_control_zero = ctrl0_q;
   assign byte_timer_run_bit = ctrl0_q[tbw_pkg::RUN_BIT];
   assign word_hold = {whold_hi_q, whold_lo_q};
   assign byte_hold_high_field = bhold_hi_q;
   assign byte_hold_low_field = bhold_lo_q;

   // Pointer written at 253 reads back next cycle.
   a_ptr_write: assert property (@(posedge clk_sys) disable iff (rst)
      wr_en && eff_addr == tbw_pkg::PTR_ADDR |=> ptr_q == $past(acc_wdata))
      else $error("pointer write lost");
   a_bank_zero: assert property (@(posedge clk_sys) disable iff (rst)
      acc_en && ptr_q[3:0] == 4'h0 |-> !bank_hit)
      else $error("bank zero substituted");
   a_bank_swap: assert property (@(posedge clk_sys) disable iff (rst)
      acc_en && ptr_q[3:0] != 4'h0 && eff_addr < 8'h10 |-> !file_sel && !port_hit)
      else $error("low registers not swapped");
   a_group_addr: assert property (@(posedge clk_sys) disable iff (rst)
      acc_short |-> file_addr[7:4] == ptr_q[7:4] && file_addr[3:0] == acc_addr[3:0])
      else $error("group address wrong");
   a_bank_sel: assert property (@(posedge clk_sys) disable iff (rst)
      acc_en && bank_hit && ptr_q[3:0] == 4'hf |-> acc_rdata == 8'h00)
      else $error("bank f not empty");
   a_byte_cap_hi: assert property (@(posedge clk_sys) disable iff (rst)
      byte_cap_high_stb |=> bcap_hi_q == $past(byte_count))
      else $error("high capture missed");
   a_byte_cap_lo: assert property (@(posedge clk_sys) disable iff (rst)
      byte_cap_low_stb |=> bcap_lo_q == $past(byte_count))
      else $error("low capture missed");
   a_word_cap_hi: assert property (@(posedge clk_sys) disable iff (rst)
      word_cap_stb |=> wcap_hi_q == $past(word_count[15:8]))
      else $error("word high capture wrong");
   a_word_cap_lo: assert property (@(posedge clk_sys) disable iff (rst)
      word_cap_stb |=> wcap_lo_q == $past(word_count[7:0]))
      else $error("word low capture wrong");
   a_word_hold: assert property (@(posedge clk_sys) disable iff (rst)
      wr_en && bank_hit && bank == tbw_pkg::BANK_TIMER && eff_addr[3:0] == tbw_pkg::OFS_WORD_HOLD_HIGH
      |=> word_hold[15:8] == $past(acc_wdata))
      else $error("word hold write lost");
   a_byte_hold: assert property (@(posedge clk_sys) disable iff (rst)
      wr_en && bank_hit && bank == tbw_pkg::BANK_TIMER && eff_addr[3:0] == tbw_pkg::OFS_BYTE_LOW_HOLD
      |=> byte_hold_low_field == $past(acc_wdata))
      else $error("byte hold write lost");
   a_run_bit: assert property (@(posedge clk_sys) disable iff (rst)
      wr_en && bank_hit && bank == tbw_pkg::BANK_TIMER && eff_addr[3:0] == tbw_pkg::OFS_CTRL0
      |=> byte_timer_run_bit == $past(acc_wdata[7]))
      else $error("run bit not written");
   a_read_same: assert property (@(posedge clk_sys) disable iff (rst)
      acc_en && !acc_wr && bank_hit && bank == tbw_pkg::BANK_TIMER && eff_addr[3:0] == 4'h5
      |-> acc_rdata == bhold_hi_q)
      else $error("read not same cycle");
   c_bank_d: cover property (@(posedge clk_sys) acc_en && bank == tbw_pkg::BANK_TIMER && bank_hit);
   c_port: cover property (@(posedge clk_sys) port_hit);
   c_cap: cover property (@(posedge clk_sys) word_cap_stb ##1 byte_cap_high_stb);
endmodule
`default_nettype wire

/* File: test/timer_bank_register_window_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module timer_bank_register_window_tb;
   logic clk_sys, rst, acc_en, acc_wr, acc_short, byte_cap_high_stb, byte_cap_low_stb, word_cap_stb;
   logic [7:0] acc_addr, acc_wdata, file_rdata, port_rdata, byte_count, ctrl1_rdata, ctrl2_rdata, ptr_m, exp_v;
   logic [7:0] acc_rdata, file_addr, work_group_pointer, timer_control_zero, byte_hold_high_field;
   logic [7:0] byte_hold_low_field;
   logic [15:0] word_count, word_hold;
   logic [1:0] port_sel;
   logic file_sel, port_hit, byte_timer_run_bit, ctrl1_wr, ctrl2_wr;
   logic [7:0] exp_q[$];
   logic [7:0] vals [16];
   int err_total, tests_run, seed;
   tbw_window DUT (.clk_sys(clk_sys), .rst(rst), .acc_en(acc_en), .acc_wr(acc_wr), .acc_short(acc_short),
      .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .file_addr(file_addr),
      .file_sel(file_sel), .port_sel(port_sel), .port_hit(port_hit), .file_rdata(file_rdata),
      .port_rdata(port_rdata), .byte_cap_high_stb(byte_cap_high_stb), .byte_cap_low_stb(byte_cap_low_stb),
      .byte_count(byte_count), .word_cap_stb(word_cap_stb), .word_count(word_count),
      .ctrl1_rdata(ctrl1_rdata), .ctrl2_rdata(ctrl2_rdata), .work_group_pointer(work_group_pointer),
      .timer_control_zero(timer_control_zero), .byte_timer_run_bit(byte_timer_run_bit),
      .word_hold(word_hold), .byte_hold_high_field(byte_hold_high_field),
      .byte_hold_low_field(byte_hold_low_field), .ctrl1_wr(ctrl1_wr), .ctrl2_wr(ctrl2_wr));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Reads queue their expected byte; the monitor below compares it in the access cycle.
   task automatic acc(input logic wr, input logic sh, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      acc_en = 1'b1;
      acc_wr = wr;
      acc_short = sh;
      acc_addr = a;
      acc_wdata = d;
      if (wr && !sh && a == tbw_pkg::PTR_ADDR) ptr_m = d;
      if (!wr) exp_q.push_back(d);
      @(negedge clk_sys);
      acc_en = 1'b0;
   endtask
   task automatic cap(input int k);
      @(negedge clk_sys);
      byte_count = 8'($random(seed));
      word_count = 16'($random(seed));
      byte_cap_high_stb = (k == 0);
      byte_cap_low_stb = (k == 1);
      word_cap_stb = (k == 2);
      @(negedge clk_sys);
      {byte_cap_high_stb, byte_cap_low_stb, word_cap_stb} = 3'b000;
   endtask
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      if (acc_en === 1'b1 && acc_wr === 1'b0 && exp_q.size() > 0) begin
         exp_v = exp_q.pop_front();
         chk(acc_rdata, exp_v);
         if (acc_short && ptr_m == 8'h00 && acc_addr < 8'h04) begin
            chk({port_hit, port_sel}, {1'b1, acc_addr[1:0]});
         end
         if (acc_short && ptr_m == 8'h20) begin
            chk({file_sel, file_addr}, {1'b1, 4'h2, acc_addr[3:0]});
         end
      end
      if (acc_en === 1'b1 && acc_wr === 1'b1) begin
         chk({ctrl1_wr, ctrl2_wr}, {acc_short && ptr_m[3:0] == 4'hd && acc_addr[3:0] == 4'h1,
            acc_short && ptr_m[3:0] == 4'hd && acc_addr[3:0] == 4'h2});
      end
   end
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial begin
      #20000;
      err_total++;
      print_verdict();
   end
   initial begin
      seed = 73;
      rst = 1'b1;
      {acc_en, acc_wr, acc_short, byte_cap_high_stb, byte_cap_low_stb, word_cap_stb} = 6'h00;
      {acc_addr, acc_wdata, byte_count, ctrl1_rdata, ctrl2_rdata} = 40'h00;
      file_rdata = 8'($random(seed));
      port_rdata = 8'h00;
      word_count = 16'h0000;
      ptr_m = 8'h00;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      rst = 1'b0;
      acc(1'b0, 1'b0, tbw_pkg::PTR_ADDR, tbw_pkg::PTR_RESET);
      for (int i = 0; i < 4; i++) begin
         port_rdata = 8'($random(seed));
         acc(1'b0, 1'b1, 8'(i), port_rdata);
      end
      acc(1'b0, 1'b1, 8'h05, file_rdata);
      acc(1'b1, 1'b0, tbw_pkg::PTR_ADDR, 8'h20);
      acc(1'b0, 1'b1, 8'h03, file_rdata);
      acc(1'b1, 1'b0, tbw_pkg::PTR_ADDR, 8'h0d);
      chk(work_group_pointer, 8'h0d);
      acc(1'b0, 1'b1, 8'h04, tbw_pkg::REG_RESET);
      for (int i = 4; i < 12; i++) begin
         vals[i] = 8'($random(seed));
         acc(1'b1, 1'b1, 8'(i), vals[i]);
      end
      for (int i = 4; i < 12; i++) acc(1'b0, 1'b1, 8'(i), vals[i]);
      chk(word_hold, {vals[7], vals[6]});
      chk({byte_hold_high_field, byte_hold_low_field}, {vals[5], vals[4]});
      cap(0);
      acc(1'b0, 1'b1, 8'h0b, byte_count);
      cap(1);
      acc(1'b0, 1'b1, 8'h0a, byte_count);
      cap(2);
      acc(1'b0, 1'b1, 8'h09, word_count[15:8]);
      acc(1'b0, 1'b1, 8'h08, word_count[7:0]);
      acc(1'b1, 1'b1, 8'h00, 8'h80);
      chk(byte_timer_run_bit, 1'b1);
      chk(timer_control_zero, 8'h80);
      acc(1'b0, 1'b1, 8'h00, 8'h80);
      acc(1'b1, 1'b1, 8'h00, 8'h00);
      chk(byte_timer_run_bit, 1'b0);
      ctrl1_rdata = 8'($random(seed));
      ctrl2_rdata = 8'($random(seed));
      acc(1'b0, 1'b1, 8'h01, ctrl1_rdata);
      acc(1'b0, 1'b1, 8'h02, ctrl2_rdata);
      acc(1'b1, 1'b1, 8'h01, 8'h5a);
      acc(1'b1, 1'b1, 8'h02, 8'ha5);
      acc(1'b1, 1'b1, 8'h03, 8'hff);
      acc(1'b0, 1'b1, 8'h03, 8'h00);
      acc(1'b1, 1'b0, tbw_pkg::PTR_ADDR, 8'h0f);
      acc(1'b1, 1'b1, 8'h05, ~vals[5]);
      acc(1'b0, 1'b1, 8'h05, 8'h00);
      acc(1'b1, 1'b0, tbw_pkg::PTR_ADDR, 8'h0d);
      acc(1'b0, 1'b1, 8'h05, vals[5]);
      // A reset in mid-run must clear the pointer, control zero, word hold, byte capture high and byte hold high.
      @(negedge clk_sys);
      rst = 1'b1;
      @(negedge clk_sys);
      rst = 1'b0;
      ptr_m = tbw_pkg::PTR_RESET;
      chk({work_group_pointer, timer_control_zero}, {tbw_pkg::PTR_RESET, tbw_pkg::REG_RESET});
      chk(word_hold, {tbw_pkg::REG_RESET, tbw_pkg::REG_RESET});
      acc(1'b1, 1'b0, tbw_pkg::PTR_ADDR, 8'h0d);
      acc(1'b0, 1'b1, 8'h0b, tbw_pkg::REG_RESET);
      acc(1'b0, 1'b1, 8'h05, tbw_pkg::REG_RESET);
      repeat (2) @(negedge clk_sys);
      print_verdict();
   end
endmodule
`default_nettype wire
